// ### src/ttc_pkg.sv
// Shared constants and types of the three-channel capture timer
package ttc_pkg;

  // Register window and data widths
  localparam logic [15:0] TTC_BASE_ADDR = 16'h0380;
  localparam int TTC_WIN_BITS = 6;
  localparam int TTC_CNT_W = 16;
  localparam int TTC_NUM_CHAN = 3;
  localparam int TTC_DIV_W = 8;

  // Byte offsets inside the 64-byte window
  localparam logic [5:0] TTC_OFS_CTRL = 6'h00;
  localparam logic [5:0] TTC_OFS_CCTL0 = 6'h02;
  localparam logic [5:0] TTC_OFS_CCTL1 = 6'h04;
  localparam logic [5:0] TTC_OFS_CCTL2 = 6'h06;
  localparam logic [5:0] TTC_OFS_COUNT = 6'h10;
  localparam logic [5:0] TTC_OFS_CAPTURE_COMPARE_CHAN0 = 6'h12;
  localparam logic [5:0] TTC_OFS_CAPTURE_COMPARE_CHAN1 = 6'h14;
  localparam logic [5:0] TTC_OFS_CAPTURE_COMPARE_CHAN2 = 6'h16;
  localparam logic [5:0] TTC_OFS_IRQ_STAT = 6'h20;
  localparam logic [5:0] TTC_OFS_IRQ_MASK = 6'h22;
  localparam logic [5:0] TTC_OFS_RADIO_DIV = 6'h24;

  // Control register fields
  localparam int TTC_CTRL_SRC_LSB = 0;
  localparam int TTC_CTRL_MODE_LSB = 2;
  localparam int TTC_CTRL_CLR_BIT = 4;

  // Channel control fields
  localparam int TTC_CC_CAP_BIT = 0;
  localparam int TTC_CC_SEL_LSB = 1;
  localparam int TTC_CC_EDGE_LSB = 3;
  localparam int TTC_CC_OMODE_LSB = 5;
  localparam int TTC_CC_OUTVAL_BIT = 8;
  localparam int TTC_CC_CCI_BIT = 9;
  localparam int TTC_CC_COV_BIT = 10;

  // Interrupt status bits: overflow, then one per channel
  localparam int TTC_IRQ_OVF_BIT = 0;
  localparam int TTC_IRQ_CH_LSB = 1;

  // Reset values
  localparam logic [15:0] TTC_CTRL_RST = 16'h0000;
  localparam logic [15:0] TTC_CCTL_RST = 16'h0000;
  localparam logic [15:0] TTC_COUNT_RST = 16'h0000;
  localparam logic [15:0] TTC_CCR_RST = 16'h0000;
  localparam logic [3:0] TTC_IRQ_RST = 4'h0;
  localparam logic [7:0] TTC_RADIO_DIV_RST = 8'hC0;

  typedef enum logic [1:0] {
    TTC_SRC_EXT = 2'b00,
    TTC_SRC_AUX = 2'b01,
    TTC_SRC_SUBMAIN = 2'b10,
    TTC_SRC_RADIO = 2'b11
  } ttc_clk_src_type;

  // Gray order along stop, up, continuous, up/down
  typedef enum logic [1:0] {
    TTC_MODE_STOP = 2'b00,
    TTC_MODE_UP = 2'b01,
    TTC_MODE_CONT = 2'b11,
    TTC_MODE_UPDOWN = 2'b10
  } ttc_mode_type;

  typedef enum logic [1:0] {
    TTC_CAP_PIN = 2'b00,
    TTC_CAP_ALT = 2'b01,
    TTC_CAP_GND = 2'b10,
    TTC_CAP_VCC = 2'b11
  } ttc_cap_sel_type;

endpackage

// ### src/ttc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ttc_sync
  import ttc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Asynchronous level in, settled level out
  input wire logic asyncIn,
  output logic syncOut
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end
    else
    begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // A single-cycle glitch past stage two never reaches the output
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      syncOut <= 1'b0;
    else if (stage2_r == stage3_r)
      syncOut <= stage3_r;
  end

endmodule
`default_nettype wire

// ### src/ttc_timer.sv
// Sixteen-bit timer with three capture/compare channels and register port
//
// Contract
// - One 16-bit counter, three capture/compare channels.
// - Capture, compare, PWM and interval timing per channel.
// - Interrupts from overflow and each channel.
// - Four clock sources, radio clock divided by 192.
// - Channel 0 captures pin, radio serial, ground, high.
// - Channel 0 output drives pin and radio input.
// - Registers sit in 64-byte window at 0380h.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ttc_timer
  import ttc_pkg::*;
#(
  parameter int CNT_W = TTC_CNT_W,
  parameter int NUM_CHAN = TTC_NUM_CHAN
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  output logic [15:0] busRdData,
  // Clock source pins
  input wire logic extTimerClockPin,
  input wire logic auxClock,
  input wire logic radioClock,
  // Capture inputs
  input wire logic [NUM_CHAN-1:0] chanPinIn,
  input wire logic radioAsyncOut,
  input wire logic comparatorOutput,
  // Compare outputs
  output logic [NUM_CHAN-1:0] chanPinOut,
  output logic [NUM_CHAN-1:0] chanPinOe,
  output logic radioAsyncIn,
  // Interrupt
  output logic timerIrq
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic outStep(input logic [2:0] mode, input logic cur,
                                   input logic outVal, input logic hitOwn,
                                   input logic hitPeriod);
    logic res;
    res = cur;
    case (mode)
      3'd0: res = outVal;
      3'd1: res = hitOwn ? 1'b1 : cur;
      3'd2: res = hitOwn ? ~cur : (hitPeriod ? 1'b0 : cur);
      3'd3: res = hitOwn ? 1'b1 : (hitPeriod ? 1'b0 : cur);
      3'd4: res = hitOwn ? ~cur : cur;
      3'd5: res = hitOwn ? 1'b0 : cur;
      3'd6: res = hitOwn ? ~cur : (hitPeriod ? 1'b1 : cur);
      3'd7: res = hitOwn ? 1'b0 : (hitPeriod ? 1'b1 : cur);
      default: res = cur;
    endcase
    return res;
  endfunction

  function automatic logic chanHit(input logic [5:0] ofs, input logic [5:0] base, input int idx);
    return ofs == 6'(base + 6'(2 * idx));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic inWindow;
  logic [5:0] regOfs;
  logic wrEn;
  logic rdEn;

  assign inWindow = busAddr[15:TTC_WIN_BITS] == TTC_BASE_ADDR[15:TTC_WIN_BITS];
  assign regOfs = busAddr[TTC_WIN_BITS-1:0];
  assign wrEn = busWr && inWindow;
  assign rdEn = busRd && inWindow;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  localparam int NUM_ASYNC = 5 + NUM_CHAN;
  logic [NUM_ASYNC-1:0] asyncPins;
  logic [NUM_ASYNC-1:0] syncPins;
  logic extClkSync;
  logic auxSync;
  logic radioClkSync;
  logic radioOutSync;
  logic cmpSync;
  logic [NUM_CHAN-1:0] chanPinSync;

  assign asyncPins = {chanPinIn, comparatorOutput, radioAsyncOut, radioClock, auxClock, extTimerClockPin};

  generate
    for (genvar g = 0; g < NUM_ASYNC; g++)
    begin : gSync
      ttc_sync uSync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(asyncPins[g]),
        .syncOut(syncPins[g])
      );
    end
  endgenerate

  assign extClkSync = syncPins[0];
  assign auxSync = syncPins[1];
  assign radioClkSync = syncPins[2];
  assign radioOutSync = syncPins[3];
  assign cmpSync = syncPins[4];
  assign chanPinSync = syncPins[NUM_ASYNC-1:5];

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] ctrl_r;
  logic [15:0] cctl_r [NUM_CHAN];
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] ccr_r [NUM_CHAN];
  logic [NUM_CHAN:0] irqStat_r;
  logic [NUM_CHAN:0] irqMask_r;
  logic [TTC_DIV_W-1:0] radioDiv_r;
  logic upDown_r;
  logic [NUM_CHAN:0] irqEvent;
  logic [NUM_CHAN-1:0] capEvent;
  logic [NUM_CHAN-1:0] capLevel;
  logic [NUM_CHAN-1:0] capPrev_r;
  logic [NUM_CHAN-1:0] outLevel_r;

  ttc_clk_src_type clkSrc;
  ttc_mode_type cntMode;

  assign clkSrc = ttc_clk_src_type'(ctrl_r[TTC_CTRL_SRC_LSB +: 2]);
  assign cntMode = ttc_mode_type'(ctrl_r[TTC_CTRL_MODE_LSB +: 2]);

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      ctrl_r <= TTC_CTRL_RST;
    else if (wrEn && regOfs == TTC_OFS_CTRL)
      ctrl_r <= busWrData & ~(16'h0001 << TTC_CTRL_CLR_BIT);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      irqMask_r <= TTC_IRQ_RST;
      radioDiv_r <= TTC_RADIO_DIV_RST;
    end
    else if (wrEn)
    begin
      if (regOfs == TTC_OFS_IRQ_MASK)
        irqMask_r <= busWrData[NUM_CHAN:0];
      if (regOfs == TTC_OFS_RADIO_DIV)
        radioDiv_r <= busWrData[TTC_DIV_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Clock source selection

  logic [TTC_DIV_W-1:0] radioCnt_r;
  logic radioPrev_r;
  logic extPrev_r;
  logic auxPrev_r;
  logic radioEdge;
  logic radioTick;
  logic tick;

  assign radioEdge = radioClkSync && !radioPrev_r;
  assign radioTick = radioEdge && (9'(radioCnt_r) + 9'd1 >= 9'(radioDiv_r));

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      radioPrev_r <= 1'b0;
      extPrev_r <= 1'b0;
      auxPrev_r <= 1'b0;
    end
    else
    begin
      radioPrev_r <= radioClkSync;
      extPrev_r <= extClkSync;
      auxPrev_r <= auxSync;
    end
  end

  // Radio clock divided by the programmable ratio, 192 after reset
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      radioCnt_r <= '0;
    else if (radioTick)
      radioCnt_r <= '0;
    else if (radioEdge)
      radioCnt_r <= radioCnt_r + 1'b1;
  end

  // The sub-main clock is the core clock itself, so it ticks every cycle
  always_comb
  begin
    case (clkSrc)
      TTC_SRC_EXT: tick = extClkSync && !extPrev_r;
      TTC_SRC_AUX: tick = auxSync && !auxPrev_r;
      TTC_SRC_SUBMAIN: tick = 1'b1;
      TTC_SRC_RADIO: tick = radioTick;
      default: tick = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter

  logic [CNT_W-1:0] count_nxt;
  logic upDown_nxt;
  logic overflow;
  logic cntClear;
  logic cntWrite;

  assign cntClear = wrEn && regOfs == TTC_OFS_CTRL && busWrData[TTC_CTRL_CLR_BIT];
  assign cntWrite = wrEn && regOfs == TTC_OFS_COUNT;

  always_comb
  begin
    count_nxt = count_r;
    upDown_nxt = upDown_r;
    overflow = 1'b0;
    if (tick)
    begin
      case (cntMode)
        TTC_MODE_UP:
        begin
          if (count_r >= ccr_r[0])
          begin
            count_nxt = '0;
            overflow = 1'b1;
          end
          else
            count_nxt = count_r + 1'b1;
        end
        TTC_MODE_CONT:
        begin
          count_nxt = count_r + 1'b1;
          overflow = &count_r;
        end
        TTC_MODE_UPDOWN:
        begin
          if (!upDown_r && count_r >= ccr_r[0])
          begin
            upDown_nxt = 1'b1;
            count_nxt = (count_r == '0) ? count_r : count_r - 1'b1;
          end
          else if (upDown_r && count_r <= 1)
          begin
            upDown_nxt = 1'b0;
            count_nxt = '0;
            overflow = 1'b1;
          end
          else
            count_nxt = upDown_r ? count_r - 1'b1 : count_r + 1'b1;
        end
        default: count_nxt = count_r;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      count_r <= TTC_COUNT_RST;
      upDown_r <= 1'b0;
    end
    else if (cntClear)
    begin
      count_r <= TTC_COUNT_RST;
      upDown_r <= 1'b0;
    end
    else if (cntWrite)
      count_r <= busWrData[CNT_W-1:0];
    else
    begin
      count_r <= count_nxt;
      upDown_r <= upDown_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels

  logic [NUM_CHAN-1:0] altInput;
  logic [NUM_CHAN-1:0] cmpEvent;

  // Channel 0 listens to the radio, channel 1 the comparator, channel 2 the aux clock
  assign altInput[0] = radioOutSync;
  assign altInput[1] = cmpSync;
  assign altInput[2] = auxSync;

  generate
    for (genvar c = 0; c < NUM_CHAN; c++)
    begin : gChan
      logic capMode;
      logic [1:0] capEdge;
      logic cctlWr;
      logic ccrWr;
      ttc_cap_sel_type capSel;

      assign capMode = cctl_r[c][TTC_CC_CAP_BIT];
      assign capEdge = cctl_r[c][TTC_CC_EDGE_LSB +: 2];
      assign capSel = ttc_cap_sel_type'(cctl_r[c][TTC_CC_SEL_LSB +: 2]);
      assign cctlWr = wrEn && chanHit(regOfs, TTC_OFS_CCTL0, c);
      assign ccrWr = wrEn && chanHit(regOfs, TTC_OFS_CAPTURE_COMPARE_CHAN0, c);

      // Switching between ground and high gives software a capture trigger
      always_comb
      begin
        case (capSel)
          TTC_CAP_PIN: capLevel[c] = chanPinSync[c];
          TTC_CAP_ALT: capLevel[c] = altInput[c];
          TTC_CAP_GND: capLevel[c] = 1'b0;
          TTC_CAP_VCC: capLevel[c] = 1'b1;
          default: capLevel[c] = 1'b0;
        endcase
      end

      assign capEvent[c] = capMode && ((capEdge[0] && capLevel[c] && !capPrev_r[c])
                                     || (capEdge[1] && !capLevel[c] && capPrev_r[c]));
      assign cmpEvent[c] = !capMode && tick && cntMode != TTC_MODE_STOP && count_nxt == ccr_r[c];

      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
          capPrev_r[c] <= 1'b0;
        else
          capPrev_r[c] <= capLevel[c];
      end

      // Capture takes priority over a software write in the same cycle
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
          ccr_r[c] <= TTC_CCR_RST;
        else if (capEvent[c])
          ccr_r[c] <= count_r;
        else if (ccrWr)
          ccr_r[c] <= busWrData[CNT_W-1:0];
      end

      // Overrun sticks when a capture lands on an unserviced flag; set beats clear
      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
          cctl_r[c] <= TTC_CCTL_RST;
        else
        begin
          if (cctlWr)
          begin
            cctl_r[c][TTC_CC_OUTVAL_BIT:0] <= busWrData[TTC_CC_OUTVAL_BIT:0];
            cctl_r[c][TTC_CC_COV_BIT] <= busWrData[TTC_CC_COV_BIT]
              || (capEvent[c] && irqStat_r[TTC_IRQ_CH_LSB + c]);
          end
          else if (capEvent[c] && irqStat_r[TTC_IRQ_CH_LSB + c])
            cctl_r[c][TTC_CC_COV_BIT] <= 1'b1;
          cctl_r[c][TTC_CC_CCI_BIT] <= capLevel[c];
          cctl_r[c][15:TTC_CC_COV_BIT+1] <= '0;
        end
      end

      always_ff @(posedge core_clk)
      begin
        if (!reset_n)
        begin
          outLevel_r[c] <= 1'b0;
          chanPinOut[c] <= 1'b0;
          chanPinOe[c] <= 1'b0;
        end
        else
        begin
          outLevel_r[c] <= outStep(cctl_r[c][TTC_CC_OMODE_LSB +: 3], outLevel_r[c],
                                   cctl_r[c][TTC_CC_OUTVAL_BIT], cmpEvent[c],
                                   cmpEvent[0] && c != 0);
          chanPinOut[c] <= outLevel_r[c];
          chanPinOe[c] <= !capMode;
        end
      end
    end
  endgenerate

  // Channel 0 output also feeds the radio serial input
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      radioAsyncIn <= 1'b0;
    else
      radioAsyncIn <= outLevel_r[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic statWr;

  assign irqEvent = {capEvent | cmpEvent, overflow};
  assign statWr = wrEn && regOfs == TTC_OFS_IRQ_STAT;

  // Write one to clear; an event in the same cycle keeps its bit set
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      irqStat_r <= TTC_IRQ_RST;
    else
      irqStat_r <= (irqStat_r & ~(statWr ? busWrData[NUM_CHAN:0] : '0)) | irqEvent;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      timerIrq <= 1'b0;
    else
      timerIrq <= |(irqStat_r & irqMask_r);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port

  logic [15:0] rdMux;

  always_comb
  begin
    rdMux = 16'h0000;
    case (regOfs)
      TTC_OFS_CTRL: rdMux = ctrl_r;
      TTC_OFS_CCTL0: rdMux = cctl_r[0];
      TTC_OFS_CCTL1: rdMux = cctl_r[1];
      TTC_OFS_CCTL2: rdMux = cctl_r[2];
      TTC_OFS_COUNT: rdMux = 16'(count_r);
      TTC_OFS_CAPTURE_COMPARE_CHAN0: rdMux = 16'(ccr_r[0]);
      TTC_OFS_CAPTURE_COMPARE_CHAN1: rdMux = 16'(ccr_r[1]);
      TTC_OFS_CAPTURE_COMPARE_CHAN2: rdMux = 16'(ccr_r[2]);
      TTC_OFS_IRQ_STAT: rdMux = 16'(irqStat_r);
      TTC_OFS_IRQ_MASK: rdMux = 16'(irqMask_r);
      TTC_OFS_RADIO_DIV: rdMux = 16'(radioDiv_r);
      default: rdMux = 16'h0000;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      busRdData <= 16'h0000;
    else if (rdEn)
      busRdData <= rdMux;
    else
      busRdData <= 16'h0000;
  end

endmodule
`default_nettype wire

// ### sim/ttc_timer_props.sv
// Port-level checker of the three-channel capture timer
`timescale 1ns/1ps
`default_nettype none
module ttc_timer_props
  import ttc_pkg::*;
#(
  parameter int CNT_W = TTC_CNT_W,
  parameter int NUM_CHAN = TTC_NUM_CHAN
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic [15:0] busRdData,
  // Outputs
  input wire logic [NUM_CHAN-1:0] chanPinOut,
  input wire logic [NUM_CHAN-1:0] chanPinOe,
  input wire logic radioAsyncIn,
  input wire logic timerIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  // Output compare on channel 0 left alone for three cycles
  sequence s_setOut;
    busWr && busAddr == 16'h0382 && busWrData[7:0] == 8'h00 ##1 !busWr [*3];
  endsequence
  a_rd_only_after:
    assert property (busRdData != 16'h0000 |-> $past(busRd))
    else $error("read data without read strobe");
  a_rd_outside:
    assert property (busRd && busAddr[15:6] != 10'h00E |=> busRdData == 16'h0000)
    else $error("read outside window returned data");
  a_rd_unmapped:
    assert property (busRd && busAddr == 16'h03BE |=> busRdData == 16'h0000)
    else $error("unmapped offset returned data");
  a_rd_one_cycle:
    assert property (busRd ##1 !busRd |=> busRdData == 16'h0000)
    else $error("read data held too long");
  a_mask_off:
    assert property (busWr && busAddr == 16'h03A2 && busWrData[3:0] == 4'h0 |-> ##2 !timerIrq)
    else $error("interrupt high with all sources masked");
  a_oe_mode:
    assert property (busWr && busAddr == 16'h0382 |-> ##2 chanPinOe[0] == !$past(busWrData[0], 2))
    else $error("output enable does not follow compare mode");
  a_out_level:
    assert property (s_setOut |-> chanPinOut[0] == $past(busWrData[8], 3))
    else $error("channel 0 pin does not show output value");
  a_radio_copy:
    assert property (radioAsyncIn == chanPinOut[0])
    else $error("radio input differs from channel 0 output");
  c_read: cover property (busRd ##1 busRdData != 16'h0000);
  c_irq: cover property ($rose(timerIrq));
  c_out: cover property ($rose(chanPinOut[0]));
endmodule
bind ttc_timer ttc_timer_props #(.CNT_W(CNT_W), .NUM_CHAN(NUM_CHAN)) i_props (.core_clk(core_clk),
  .reset_n(reset_n), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
  .busRdData(busRdData), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe), .radioAsyncIn(radioAsyncIn),
  .timerIrq(timerIrq));
`default_nettype wire

// ### sim/ttc_far_model.sv
// Far side of the timer: clock sources, capture pins, radio and comparator
`timescale 1ns/1ps
`default_nettype none
module ttc_far_model
(
  // Clock
  input wire logic core_clk,
  // Levels fed to the timer
  output logic extTimerClockPin,
  output logic auxClock,
  output logic radioClock,
  output logic [2:0] chanPinIn,
  output logic radioAsyncOut,
  output logic comparatorOutput
);
  // Bits: 0 ext, 1 aux, 2 radio, 3..5 pins, 6 radio serial, 7 comparator
  logic [7:0] lvl = 8'h00;
  assign {comparatorOutput, radioAsyncOut, chanPinIn, radioClock, auxClock, extTimerClockPin} = lvl;
  ////////////////////////////////////////////////////////////////
  task automatic drive(input int i, input logic v);
    @(posedge core_clk);
    lvl[i] <= v;
  endtask
  // Slow edges so the three-flop synchroniser sees each level
  task automatic pulse(input int i, input int n);
    repeat (n)
    begin
      drive(i, 1'b1);
      repeat (3) @(posedge core_clk);
      drive(i, 1'b0);
      repeat (3) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### sim/three_channel_capture_timer_tb_top.sv
// Self-checking bench of the three-channel capture timer
`timescale 1ns/1ps
`default_nettype none
module three_channel_capture_timer_tb_top
  import ttc_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] busAddr = 16'h0000;
  logic [15:0] busWrData = 16'h0000;
  logic busWr = 1'b0;
  logic busRd = 1'b0;
  logic rdSeen = 1'b0;
  logic [15:0] busRdData;
  logic extTimerClockPin, auxClock, radioClock, radioAsyncOut, comparatorOutput, radioAsyncIn, timerIrq;
  logic [2:0] chanPinIn, chanPinOut, chanPinOe;
  logic [15:0] expQ[$];
  logic [15:0] mskQ[$];
  logic [15:0] ccrExp[3];
  int failures = 0;
  int n_tests = 0;
  ttc_timer i_dut (.core_clk(core_clk), .reset_n(reset_n), .busAddr(busAddr), .busWrData(busWrData),
    .busWr(busWr), .busRd(busRd), .busRdData(busRdData), .extTimerClockPin(extTimerClockPin),
    .auxClock(auxClock), .radioClock(radioClock), .chanPinIn(chanPinIn), .radioAsyncOut(radioAsyncOut),
    .comparatorOutput(comparatorOutput), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe),
    .radioAsyncIn(radioAsyncIn), .timerIrq(timerIrq));
  ttc_far_model i_far (.core_clk(core_clk), .extTimerClockPin(extTimerClockPin), .auxClock(auxClock),
    .radioClock(radioClock), .chanPinIn(chanPinIn), .radioAsyncOut(radioAsyncOut),
    .comparatorOutput(comparatorOutput));
  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ad(input logic [5:0] o);
    return TTC_BASE_ADDR | {10'h000, o};
  endfunction
  // Far-side line feeding a channel: pin, else its alternate source
  function automatic int srcOf(input int ch, input int sel);
    return (sel == 0) ? 3 + ch : (ch == 0) ? 6 : (ch == 1) ? 7 : 1;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      failures++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle(input int n);
    busWr <= 1'b0;
    busRd <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    busAddr <= a;
    busWrData <= d;
    busWr <= 1'b1;
    busRd <= 1'b0;
    @(posedge core_clk);
  endtask
  // Masked-off bits are don't-care in the comparison
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] m);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    busAddr <= a;
    busRd <= 1'b1;
    busWr <= 1'b0;
    @(posedge core_clk);
  endtask
  // Sampled at the falling edge, away from the edge that launches the level
  task automatic waitIrq(input logic lvl);
    int n;
    n = 0;
    idle(1);
    @(negedge core_clk);
    while (timerIrq !== lvl && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("timerIrq", 16'(lvl), 16'(timerIrq));
    @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rdSeen <= busRd;
  end
  always @(negedge core_clk)
  begin
    if (rdSeen === 1'b1)
    begin
      if (expQ.size() == 0)
        chk("readQueue", 16'h0001, 16'h0000);
      else
        chk("busRdData", expQ.pop_front(), busRdData & mskQ.pop_front());
    end
  end
  initial
  begin
    repeat (100000) @(posedge core_clk);
    failures++;
    final_report();
  end
  initial
  begin
    logic [15:0] cv;
    logic [15:0] cc;
    int hi;
    void'($urandom(8));
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(ad(TTC_OFS_CTRL), TTC_CTRL_RST, 16'hFFFF);
    rd(ad(TTC_OFS_RADIO_DIV), {8'h00, TTC_RADIO_DIV_RST}, 16'hFFFF);
    rd(ad(TTC_OFS_IRQ_STAT), {12'h000, TTC_IRQ_RST}, 16'hFFFF);
    rd(ad(6'h3E), 16'h0000, 16'hFFFF);
    wr(16'h0340, 16'h000E);
    rd(16'h0340, 16'h0000, 16'hFFFF);
    rd(ad(TTC_OFS_CTRL), 16'h0000, 16'hFFFF);
    for (int i = 0; i < 3; i++)
    begin
      ccrExp[i] = 16'($urandom);
      wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN0 + 6'(2 * i)), ccrExp[i]);
    end
    for (int i = 0; i < 3; i++)
      rd(ad(TTC_OFS_CAPTURE_COMPARE_CHAN0 + 6'(2 * i)), ccrExp[i], 16'hFFFF);
    // Ext pin, aux clock, radio clock over a divider of four
    wr(ad(TTC_OFS_RADIO_DIV), 16'h0004);
    for (int k = 0; k < 3; k++)
    begin
      wr(ad(TTC_OFS_COUNT), 16'h0000);
      wr(ad(TTC_OFS_CTRL), 16'h000C | 16'((k == 2) ? 3 : k));
      idle(2);
      i_far.pulse(k, 8);
      idle(12);
      wr(ad(TTC_OFS_CTRL), 16'h0000);
      rd(ad(TTC_OFS_COUNT), (k == 2) ? 16'h0002 : 16'h0008, 16'hFFFF);
    end
    // Stop, up and up/down modes from count 5 with channel 0 compare at 9
    wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN0), 16'h0009);
    for (int k = 0; k < 3; k++)
    begin
      wr(ad(TTC_OFS_IRQ_STAT), 16'h000F);
      wr(ad(TTC_OFS_COUNT), 16'h0005);
      wr(ad(TTC_OFS_CTRL), (k == 0) ? 16'h0002 : (k == 1) ? 16'h0006 : 16'h000A);
      idle(30);
      wr(ad(TTC_OFS_CTRL), 16'h0000);
      rd(ad(TTC_OFS_IRQ_STAT), (k == 0) ? 16'h0000 : 16'h0001, 16'h0001);
    end
    wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN0), 16'hFFF8);
    wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN1), 16'h8000);
    wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN2), 16'h8000);
    wr(ad(TTC_OFS_COUNT), 16'hFFF0);
    wr(ad(TTC_OFS_IRQ_STAT), 16'h000F);
    wr(ad(TTC_OFS_CTRL), 16'h000E);
    idle(40);
    wr(ad(TTC_OFS_CTRL), 16'h0000);
    rd(ad(TTC_OFS_IRQ_STAT), 16'h0003, 16'h000F);
    wr(ad(TTC_OFS_IRQ_MASK), 16'h0002);
    waitIrq(1'b1);
    wr(ad(TTC_OFS_IRQ_MASK), 16'h0000);
    waitIrq(1'b0);
    wr(ad(TTC_OFS_IRQ_MASK), 16'h0003);
    wr(ad(TTC_OFS_IRQ_STAT), 16'h0003);
    waitIrq(1'b0);
    rd(ad(TTC_OFS_IRQ_STAT), 16'h0000, 16'h000F);
    // Capture with every input select; counter stopped so the value is known
    for (int ch = 0; ch < 3; ch++)
    begin
      for (int sel = 0; sel < 4; sel++)
      begin
        cv = 16'($urandom);
        cc = 16'h0009 | 16'(sel << 1);
        wr(ad(TTC_OFS_IRQ_STAT), 16'h000F);
        wr(ad(TTC_OFS_COUNT), cv);
        wr(ad(TTC_OFS_CCTL0 + 6'(2 * ch)), cc);
        idle(8);
        if (sel < 2)
        begin
          i_far.drive(srcOf(ch, sel), 1'b1);
          ccrExp[ch] = cv;
        end
        idle(10);
        rd(ad(TTC_OFS_CCTL0 + 6'(2 * ch)), cc | ((sel == 2) ? 16'h0000 : 16'h0200), (sel == 3) ? 16'h0200 : 16'hFFFF);
        if (sel < 3)
        begin
          rd(ad(TTC_OFS_CAPTURE_COMPARE_CHAN0 + 6'(2 * ch)), ccrExp[ch], 16'hFFFF);
          rd(ad(TTC_OFS_IRQ_STAT), (sel < 2) ? 16'(2 << ch) : 16'h0000, 16'h000F);
        end
        idle(1);
        if (sel < 2)
          i_far.drive(srcOf(ch, sel), 1'b0);
      end
    end
    // Output mode 0 drives the stored level to the pins
    for (int ch = 0; ch < 3; ch++)
    begin
      for (int b = 1; b >= 0; b--)
      begin
        wr(ad(TTC_OFS_CCTL0 + 6'(2 * ch)), (b == 1) ? 16'h0100 : 16'h0000);
        idle(6);
        chk("chanPinOut", 16'(b), 16'(chanPinOut[ch]));
        chk("chanPinOe", 16'h0001, 16'(chanPinOe[ch]));
        if (ch == 0)
          chk("radioAsyncIn", 16'(b), 16'(radioAsyncIn));
      end
    end
    // Modes 1 to 7 on channel 1: period of 10 counts, own match at 3, high cycles out of 100
    wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN0), 16'h0009);
    wr(ad(TTC_OFS_CAPTURE_COMPARE_CHAN1), 16'h0003);
    wr(ad(TTC_OFS_CTRL), 16'h0006);
    for (int m = 1; m < 8; m++)
    begin
      wr(ad(TTC_OFS_CCTL1), 16'(m << 5));
      idle(20);
      hi = 0;
      repeat (100)
      begin
        @(negedge core_clk);
        hi += chanPinOut[1];
      end
      chk("pwmHigh", 16'((m == 1) ? 100 : (m == 4) ? 50 : (m == 5) ? 0 : (m < 4) ? 60 : 40), 16'(hi));
      @(posedge core_clk);
    end
    wr(ad(TTC_OFS_CTRL), 16'h0000);
    idle(4);
    final_report();
  end
endmodule
`default_nettype wire
